// ===== pkg/ips_setting_regs.vh
// Purpose: Constants for the pump setting register bank
// Assumes: Holding register addresses are word addresses, one 16-bit word each
// Notes:   Each 32-bit setting spans the listed address (upper) and the next (lower)
`ifndef IPS_SETTING_REGS_VH
`define IPS_SETTING_REGS_VH

// ============================================================
// Holding register map
`define IPS_ADDR_W            20
`define IPS_NUM_PARAMS        30
`define IPS_BASE_ADDR         20'h61EBA
`define IPS_LAST_ADDR         20'h61EF5
`define IPS_OFF_RUN_STATE     20'h61EBA
`define IPS_OFF_ALARM_RESP    20'h61EBC
`define IPS_OFF_DOSING        20'h61EBE
`define IPS_OFF_ACTIVE_SEC    20'h61EC0
`define IPS_OFF_IDLE_SEC      20'h61EC2
`define IPS_OFF_ACTIVE_CYC    20'h61EC4
`define IPS_OFF_ACTIVE_LIMIT  20'h61EC6
`define IPS_OFF_ENERGY        20'h61EC8
`define IPS_OFF_MEASURE       20'h61ECA
`define IPS_OFF_PRESS_ZERO    20'h61ECC
`define IPS_OFF_PRESS_GAIN    20'h61ECE
`define IPS_OFF_PULSES        20'h61ED0
`define IPS_OFF_TARGET_FLOW   20'h61ED2
`define IPS_OFF_PRESS_UPPER   20'h61ED4
`define IPS_OFF_PRESS_LOWER   20'h61ED6
`define IPS_OFF_SAVE_VOLT     20'h61ED8
`define IPS_OFF_CUTOFF_VOLT   20'h61EDA
`define IPS_OFF_IN1_POL       20'h61EDC
`define IPS_OFF_IN2_POL       20'h61EDE
`define IPS_OFF_REMOTE_POL    20'h61EE0
`define IPS_OFF_AVG_WINDOW    20'h61EE2
`define IPS_OFF_RES_WARN      20'h61EE4
`define IPS_OFF_RES_STOP      20'h61EE6
`define IPS_OFF_CHECK_ON      20'h61EE8
`define IPS_OFF_CHECK_TOL     20'h61EEA
`define IPS_OFF_LOOP_MIN_FLOW 20'h61EEC
`define IPS_OFF_LOOP_MAX_FLOW 20'h61EEE
`define IPS_OFF_LOOP_SELECT   20'h61EF0
`define IPS_OFF_LOOP_LOW      20'h61EF2
`define IPS_OFF_LOOP_HIGH     20'h61EF4

// ============================================================
// Field limits and encodings
`define IPS_RUN_STANDBY       32'h00000000
`define IPS_RUN_RUN           32'h00000001
`define IPS_RUN_LOCK_ALARM    32'h00000002
`define IPS_RUN_LOCK_REMOTE   32'h00000003
`define IPS_DOSING_MAX        32'h00000002
`define IPS_ENERGY_MAX        32'h00000004
`define IPS_ENERGY_DEFAULT    32'h00000003
`define IPS_MEASURE_MAX       32'h00000001
`define IPS_PULSES_MIN        32'h00000001
`define IPS_PULSES_MAX        32'h0000270F
`define IPS_FLOW_MIN          32'h0000000A
`define IPS_FLOW_MAX          32'h0000EA60
`define IPS_POL_MAX           32'h00000002
`define IPS_AVG_MAX           32'h00000002
`define IPS_CHECK_MAX         32'h00000001
`define IPS_RES_MAX           32'h0000270F
`define IPS_LOOP_MIN          32'h00000190
`define IPS_LOOP_MAX          32'h000007D0
`define IPS_AVG_MIN_SHORT     4'h1
`define IPS_AVG_MIN_MEDIUM    4'h5
`define IPS_AVG_MIN_LONG      4'hA

`endif

// ===== hw/ips_setting_bank.v
// Purpose: Writable 32-bit setting bank of the injection pump, reached as holding registers
// Assumes: Request strobes and lockouts come on clk_i; the tank detect comes from a pin
// Notes:   Upper word is staged, the lower word write commits and coerces the whole value
`timescale 1ns/1ps
`include "ips_setting_regs.vh"

// Operation
// R1: Run state takes only 0 standby or 1 run on write and reads 2 or 3 during lockouts.
// R2: Out-of-range writes to mode, units, alarm triggers and interval store and return 0.
// R3: Power save level holds 0 to 4 and an out-of-range write stores 3.
// R4: Pulses per volume below 1 becomes 1 and above 9999 becomes 9999.
// R5: Target flow is clamped to 10..60000 and applies in flow mode without loop input.
// R6: Low loop current is clamped between 400 and the high setpoint minus one.
// R7: High loop current is clamped between the low setpoint plus two and 2000.
// R8: Both alarm input and remote-off polarity fields encode 0 off, 1 NC, 2 NO.
// R9: Averaging window 0, 1, 2 selects 1, 5 or 10 minutes.
// R10: Flow check enable keeps 0 or 1 and stores 0 for any other value.
// R11: Reservoir levels hold 0..9999 and act only with the tank level module fitted; the bank stores larger values raw and outputs 0 for them.
// R12: Each setting is two words, upper at the even address, and both must be written.
module ips_setting_bank (
  input  wire                    clk_i,
  input  wire                    nrst_i,
  input  wire                    hr_wr_i,
  input  wire                    hr_rd_i,
  input  wire [`IPS_ADDR_W-1:0]  hr_addr_i,
  input  wire [15:0]             hr_wdata_i,
  input  wire                    lockout_alarm_i,
  input  wire                    lockout_remote_i,
  input  wire                    tank_level_module_i,
  output reg  [15:0]             hr_rdata_o,
  output reg                     hr_ack_o,
  output reg                     hr_err_o,
  output reg                     run_cmd_o,
  output reg  [1:0]              dosing_method_o,
  output reg  [2:0]              energy_saving_o,
  output reg                     measure_metric_o,
  output reg  [13:0]             pulses_per_volume_o,
  output reg  [15:0]             target_flow_o,
  output reg                     target_flow_active_o,
  output reg  [1:0]              input_one_polarity_o,
  output reg  [1:0]              input_two_polarity_o,
  output reg  [1:0]              remote_stop_polarity_o,
  output reg  [3:0]              averaging_minutes_o,
  output reg  [13:0]             reservoir_warn_o,
  output reg  [13:0]             reservoir_stop_o,
  output reg                     dose_check_o,
  output reg                     loop_input_on_o,
  output reg  [10:0]             loop_low_current_o,
  output reg  [10:0]             loop_high_current_o
);

  // ============================================================
  // Reset synchroniser
  reg        rst_meta_reg;
  reg        rst_sync_reg;

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ============================================================
  // Tank module detect, a strap pin from outside the clock domain
  reg        tank_meta_reg;
  reg        tank_sync_reg;

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tank_meta_reg <= 1'b0;
      tank_sync_reg <= 1'b0;
    end else begin
      tank_meta_reg <= tank_level_module_i;
      tank_sync_reg <= tank_meta_reg;
    end
  end

  // ============================================================
  // Functions
  function addr_ok;
    input [`IPS_ADDR_W-1:0] a;
    begin
      addr_ok = (a >= `IPS_BASE_ADDR) && (a <= `IPS_LAST_ADDR);
    end
  endfunction

  function [4:0] addr_idx;
    input [`IPS_ADDR_W-1:0] a;
    reg   [`IPS_ADDR_W-1:0] d;
    begin
      d        = a - `IPS_BASE_ADDR;
      addr_idx = d[5:1];
    end
  endfunction

  function [`IPS_ADDR_W-1:0] idx_addr;
    input [4:0] i;
    begin
      idx_addr = `IPS_BASE_ADDR + {{(`IPS_ADDR_W-6){1'b0}}, i, 1'b0};
    end
  endfunction

  function [31:0] reset_val;
    input [4:0] i;
    begin
      case (idx_addr(i))
        `IPS_OFF_ENERGY:        reset_val = `IPS_ENERGY_DEFAULT;
        `IPS_OFF_PULSES:        reset_val = `IPS_PULSES_MIN;
        `IPS_OFF_TARGET_FLOW:   reset_val = `IPS_FLOW_MIN;
        `IPS_OFF_LOOP_MIN_FLOW: reset_val = `IPS_FLOW_MIN;
        `IPS_OFF_LOOP_MAX_FLOW: reset_val = `IPS_FLOW_MAX;
        `IPS_OFF_LOOP_LOW:      reset_val = `IPS_LOOP_MIN;
        `IPS_OFF_LOOP_HIGH:     reset_val = `IPS_LOOP_MAX;
        default:                reset_val = 32'h00000000;
      endcase
    end
  endfunction

  // Range handling applied when the lower word commits a value
  function [31:0] coerce;
    input [`IPS_ADDR_W-1:0] off;
    input [31:0]            v;
    input [31:0]            lo_cur;
    input [31:0]            hi_cur;
    reg   [31:0]            lim;
    begin
      coerce = v;
      case (off)
        `IPS_OFF_RUN_STATE:
          // Only standby or run is accepted; other values leave standby
          coerce = (v == `IPS_RUN_RUN) ? `IPS_RUN_RUN : `IPS_RUN_STANDBY; // R1
        `IPS_OFF_DOSING:
          coerce = (v > `IPS_DOSING_MAX) ? 32'h00000000 : v; // R2
        `IPS_OFF_MEASURE:
          coerce = (v > `IPS_MEASURE_MAX) ? 32'h00000000 : v; // R2
        `IPS_OFF_ENERGY:
          coerce = (v > `IPS_ENERGY_MAX) ? `IPS_ENERGY_DEFAULT : v; // R3
        `IPS_OFF_PULSES: begin
          if (v < `IPS_PULSES_MIN) coerce = `IPS_PULSES_MIN; // R4
          else if (v > `IPS_PULSES_MAX) coerce = `IPS_PULSES_MAX; // R4
        end
        `IPS_OFF_TARGET_FLOW: begin
          if (v < `IPS_FLOW_MIN) coerce = `IPS_FLOW_MIN; // R5
          else if (v > `IPS_FLOW_MAX) coerce = `IPS_FLOW_MAX; // R5
        end
        `IPS_OFF_IN1_POL, `IPS_OFF_IN2_POL:
          coerce = (v > `IPS_POL_MAX) ? 32'h00000000 : v; // R2 R8
        `IPS_OFF_AVG_WINDOW:
          coerce = (v > `IPS_AVG_MAX) ? 32'h00000000 : v; // R2 R9
        `IPS_OFF_CHECK_ON:
          coerce = (v > `IPS_CHECK_MAX) ? 32'h00000000 : v; // R10
        `IPS_OFF_LOOP_LOW: begin
          lim = hi_cur - 32'h00000001;
          if (v < `IPS_LOOP_MIN) coerce = `IPS_LOOP_MIN; // R6
          else if (v > lim) coerce = lim; // R6
        end
        `IPS_OFF_LOOP_HIGH: begin
          // Gap of two keeps the strict low plus one ordering
          lim = lo_cur + 32'h00000002;
          if (lim > `IPS_LOOP_MAX) lim = `IPS_LOOP_MAX;
          if (v > `IPS_LOOP_MAX) coerce = `IPS_LOOP_MAX; // R7
          else if (v < lim) coerce = lim; // R7
        end
        default: coerce = v;
      endcase
    end
  endfunction

  function [3:0] avg_minutes;
    input [1:0] sel;
    begin
      case (sel)
        2'h1:    avg_minutes = `IPS_AVG_MIN_MEDIUM; // R9
        2'h2:    avg_minutes = `IPS_AVG_MIN_LONG; // R9
        default: avg_minutes = `IPS_AVG_MIN_SHORT; // R9
      endcase
    end
  endfunction

  function [31:0] run_view;
    input [31:0] stored;
    input        alarm;
    input        remote;
    begin
      if (alarm) run_view = `IPS_RUN_LOCK_ALARM; // R1
      else if (remote) run_view = `IPS_RUN_LOCK_REMOTE; // R1
      else run_view = stored;
    end
  endfunction

  // ============================================================
  // Storage
  reg [31:0] bank_reg [0:`IPS_NUM_PARAMS-1];
  reg [15:0] stage_hi_reg;
  reg [4:0]  stage_idx_reg;
  reg        stage_vld_reg;
  reg [15:0] snap_lo_reg;
  reg [4:0]  snap_idx_reg;
  reg        snap_vld_reg;

  wire        req_ok    = addr_ok(hr_addr_i);
  wire [4:0]  req_idx   = addr_idx(hr_addr_i);
  wire        req_lower = hr_addr_i[0];
  wire [31:0] lo_cur    = bank_reg[addr_idx(`IPS_OFF_LOOP_LOW)];
  wire [31:0] hi_cur    = bank_reg[addr_idx(`IPS_OFF_LOOP_HIGH)];
  wire [31:0] wr_full   = {stage_hi_reg, hr_wdata_i};
  wire        commit    = hr_wr_i && req_ok && req_lower
                          && stage_vld_reg && (stage_idx_reg == req_idx);
  // Unmapped requests and orphan lower words are refused
  wire        bad_addr  = (hr_wr_i || hr_rd_i) && !req_ok;
  wire        orphan_lo = hr_wr_i && req_ok && req_lower && !commit;

  // Lockouts override the stored command on read
  reg  [31:0] view;
  always @* begin
    view = bank_reg[req_idx];
    if (req_idx == addr_idx(`IPS_OFF_RUN_STATE)) begin
      view = run_view(bank_reg[req_idx], lockout_alarm_i, lockout_remote_i); // R1
    end
  end

  // ============================================================
  // Write path
  integer k;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      // Legal codes, lowest except energy 3 and the upper flow and loop limits, so every output starts in range
      for (k = 0; k < `IPS_NUM_PARAMS; k = k + 1) begin
        bank_reg[k] <= reset_val(k[4:0]);
      end
      stage_hi_reg  <= 16'h0000;
      stage_idx_reg <= 5'h00;
      stage_vld_reg <= 1'b0;
    end else if (hr_wr_i && req_ok) begin
      // A new upper word replaces whatever was staged
      if (!req_lower) begin
        stage_hi_reg  <= hr_wdata_i; // R12
        stage_idx_reg <= req_idx;
        stage_vld_reg <= 1'b1;
      end else begin
        // A lower word without its upper half is dropped
        stage_vld_reg <= 1'b0; // R12
        if (commit) begin
          bank_reg[req_idx] <= coerce(hr_addr_i - 20'h00001, wr_full, lo_cur, hi_cur);
        end
      end
    end
  end

  // ============================================================
  // Read path and answer
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      hr_rdata_o   <= 16'h0000;
      hr_ack_o     <= 1'b0;
      hr_err_o     <= 1'b0;
      snap_lo_reg  <= 16'h0000;
      snap_idx_reg <= 5'h00;
      snap_vld_reg <= 1'b0;
    end else begin
      // Every strobe is answered; refused ones carry the error flag
      hr_ack_o <= hr_wr_i || hr_rd_i;
      hr_err_o <= bad_addr || orphan_lo; // R12
      if (hr_rd_i && req_ok) begin
        if (!req_lower) begin
          // Snapshot keeps both halves of one read coherent
          hr_rdata_o   <= view[31:16];
          snap_lo_reg  <= view[15:0];
          snap_idx_reg <= req_idx;
          snap_vld_reg <= 1'b1;
        end else begin
          hr_rdata_o   <= (snap_vld_reg && snap_idx_reg == req_idx) ?
                          snap_lo_reg : view[15:0];
          snap_vld_reg <= 1'b0;
        end
      end else if (hr_rd_i) begin
        hr_rdata_o <= 16'h0000;
      end
    end
  end

  // ============================================================
  // Settings presented to the pump logic
  // Pump-side copies lag the bank by one edge
  wire [31:0] dosing_w  = bank_reg[addr_idx(`IPS_OFF_DOSING)];
  wire [31:0] select_w  = bank_reg[addr_idx(`IPS_OFF_LOOP_SELECT)];
  wire [31:0] avg_w     = bank_reg[addr_idx(`IPS_OFF_AVG_WINDOW)];
  wire [31:0] energy_w  = bank_reg[addr_idx(`IPS_OFF_ENERGY)];
  wire [31:0] pulses_w  = bank_reg[addr_idx(`IPS_OFF_PULSES)];
  wire [31:0] flow_w    = bank_reg[addr_idx(`IPS_OFF_TARGET_FLOW)];
  wire [31:0] warn_w    = bank_reg[addr_idx(`IPS_OFF_RES_WARN)];
  wire [31:0] stop_w    = bank_reg[addr_idx(`IPS_OFF_RES_STOP)];
  wire [31:0] in1_w     = bank_reg[addr_idx(`IPS_OFF_IN1_POL)];
  wire [31:0] in2_w     = bank_reg[addr_idx(`IPS_OFF_IN2_POL)];
  wire [31:0] rem_w     = bank_reg[addr_idx(`IPS_OFF_REMOTE_POL)];

  // ============================================================
  // Gating shared by fields of one kind
  wire [31:0] level_w     [0:1];
  wire [13:0] level_gated [0:1];
  wire [31:0] pol_w       [0:2];
  wire [1:0]  pol_code    [0:2];

  assign level_w[0] = warn_w;
  assign level_w[1] = stop_w;
  assign pol_w[0]   = in1_w;
  assign pol_w[1]   = in2_w;
  assign pol_w[2]   = rem_w;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_level
      // Levels above the limit stay raw in the bank but never reach the pump
      assign level_gated[g] = (tank_sync_reg && level_w[g] <= `IPS_RES_MAX) ?
                              level_w[g][13:0] : 14'h0000; // R11
    end

    for (g = 0; g < 3; g = g + 1) begin : g_pol
      // Remote polarity is kept raw, so codes above 2 leave it disabled
      assign pol_code[g] = (pol_w[g] > `IPS_POL_MAX) ? 2'h0 : pol_w[g][1:0]; // R8
    end
  endgenerate

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      run_cmd_o              <= 1'b0;
      dosing_method_o        <= 2'h0;
      energy_saving_o        <= 3'h3;
      measure_metric_o       <= 1'b0;
      pulses_per_volume_o    <= 14'h0001;
      target_flow_o          <= 16'h000A;
      target_flow_active_o   <= 1'b0;
      input_one_polarity_o   <= 2'h0;
      input_two_polarity_o   <= 2'h0;
      remote_stop_polarity_o <= 2'h0;
      averaging_minutes_o    <= `IPS_AVG_MIN_SHORT;
      reservoir_warn_o       <= 14'h0000;
      reservoir_stop_o       <= 14'h0000;
      dose_check_o           <= 1'b0;
      loop_input_on_o        <= 1'b0;
      loop_low_current_o     <= 11'h190;
      loop_high_current_o    <= 11'h7D0;
    end else begin
      run_cmd_o              <= (run_view(bank_reg[addr_idx(`IPS_OFF_RUN_STATE)],
                                lockout_alarm_i, lockout_remote_i) == `IPS_RUN_RUN); // R1
      dosing_method_o        <= dosing_w[1:0];
      energy_saving_o        <= energy_w[2:0];
      measure_metric_o       <= bank_reg[addr_idx(`IPS_OFF_MEASURE)][0];
      pulses_per_volume_o    <= pulses_w[13:0];
      target_flow_o          <= flow_w[15:0];
      target_flow_active_o   <= (dosing_w == 32'h00000000)
                                && (select_w == 32'h00000000); // R5
      input_one_polarity_o   <= pol_code[0]; // R8
      input_two_polarity_o   <= pol_code[1]; // R8
      remote_stop_polarity_o <= pol_code[2]; // R8
      averaging_minutes_o    <= avg_minutes(avg_w[1:0]); // R9
      reservoir_warn_o       <= level_gated[0]; // R11
      reservoir_stop_o       <= level_gated[1]; // R11
      dose_check_o           <= bank_reg[addr_idx(`IPS_OFF_CHECK_ON)][0]; // R10
      loop_input_on_o        <= select_w[0];
      loop_low_current_o     <= lo_cur[10:0]; // R6
      loop_high_current_o    <= hi_cur[10:0]; // R7
    end
  end

endmodule // ips_setting_bank

// ===== testbench/ips_setting_bank_monitor.sv
// Purpose: Port-level assertions for the setting bank
// Assumes: Single clock domain, nrst_i active low
// Notes:   Bound to every ips_setting_bank instance
`timescale 1ns/1ps
module ips_setting_bank_monitor (
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        hr_wr_i,
  input wire logic        hr_rd_i,
  input wire logic        hr_ack_o,
  input wire logic        hr_err_o,
  input wire logic        lockout_alarm_i,
  input wire logic        lockout_remote_i,
  input wire logic        tank_level_module_i,
  input wire logic        run_cmd_o,
  input wire logic [2:0]  energy_saving_o,
  input wire logic [13:0] pulses_per_volume_o,
  input wire logic [15:0] target_flow_o,
  input wire logic [3:0]  averaging_minutes_o,
  input wire logic [1:0]  input_one_polarity_o,
  input wire logic [13:0] reservoir_warn_o,
  input wire logic [10:0] loop_low_current_o,
  input wire logic [10:0] loop_high_current_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_req;
    hr_wr_i || hr_rd_i;
  endsequence
  sequence s_ack;
    ##1 hr_ack_o;
  endsequence
  a_ack_follows_req: assert property (s_req |-> s_ack)
    else $error("no ack after strobe");
  a_ack_has_cause: assert property (hr_ack_o |-> $past(hr_wr_i || hr_rd_i))
    else $error("ack without strobe");
  a_err_with_ack: assert property (hr_err_o |-> hr_ack_o)
    else $error("err without ack");
  a_lockout_stops_run: assert property ((lockout_alarm_i || lockout_remote_i) |=> !run_cmd_o)
    else $error("run during lockout");
  a_energy_in_range: assert property (energy_saving_o <= 3'h4)
    else $error("energy level out of range");
  a_pulses_clamped: assert property (pulses_per_volume_o inside {[14'h0001:14'h270F]})
    else $error("pulses out of range");
  a_flow_clamped: assert property (target_flow_o inside {[16'h000A:16'hEA60]})
    else $error("target flow out of range");
  a_loop_ordered: assert property (loop_low_current_o >= 11'h190 &&
    loop_high_current_o <= 11'h7D0 && loop_low_current_o < loop_high_current_o)
    else $error("loop setpoints disordered");
  a_window_mapped: assert property (averaging_minutes_o inside {4'h1, 4'h5, 4'hA})
    else $error("averaging minutes invalid");
  a_polarity_coded: assert property (input_one_polarity_o <= 2'h2)
    else $error("polarity code invalid");
  a_level_needs_module: assert property ((!tank_level_module_i)[*3] |=>
    reservoir_warn_o == 14'h0)
    else $error("level without module");
endmodule // ips_setting_bank_monitor
bind ips_setting_bank ips_setting_bank_monitor ips_setting_bank_monitor_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .hr_wr_i(hr_wr_i), .hr_rd_i(hr_rd_i),
  .hr_ack_o(hr_ack_o), .hr_err_o(hr_err_o), .lockout_alarm_i(lockout_alarm_i),
  .lockout_remote_i(lockout_remote_i), .tank_level_module_i(tank_level_module_i),
  .run_cmd_o(run_cmd_o), .energy_saving_o(energy_saving_o),
  .pulses_per_volume_o(pulses_per_volume_o), .target_flow_o(target_flow_o),
  .averaging_minutes_o(averaging_minutes_o), .input_one_polarity_o(input_one_polarity_o),
  .reservoir_warn_o(reservoir_warn_o), .loop_low_current_o(loop_low_current_o),
  .loop_high_current_o(loop_high_current_o));

// ===== testbench/ips_modbus_master.sv
// Purpose: Holding-register master model driving the bank strobes
// Assumes: One strobe pulse per word, answer one cycle later
// Notes:   Address and data are inverted once released
`timescale 1ns/1ps
`include "ips_setting_regs.vh"
module ips_modbus_master (
  input  wire logic                   clk_i,
  input  wire logic [15:0]            hr_rdata_i,
  input  wire logic                   hr_ack_i,
  input  wire logic                   hr_err_i,
  output logic                        hr_wr_o,
  output logic                        hr_rd_o,
  output logic [`IPS_ADDR_W-1:0]      hr_addr_o,
  output logic [15:0]                 hr_wdata_o
);
  initial begin
    hr_wr_o = 1'b0;
    hr_rd_o = 1'b0;
    hr_addr_o = '0;
    hr_wdata_o = 16'h0000;
  end
  task automatic xfer(input logic w, input logic [`IPS_ADDR_W-1:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic k, output logic e);
    @(posedge clk_i);
    hr_wr_o <= w;
    hr_rd_o <= !w;
    hr_addr_o <= a;
    hr_wdata_o <= d;
    @(posedge clk_i);
    hr_wr_o <= 1'b0;
    hr_rd_o <= 1'b0;
    @(posedge clk_i);
    q = hr_rdata_i;
    k = hr_ack_i;
    e = hr_err_i;
    // Stale values must not look valid
    hr_addr_o <= ~a;
    hr_wdata_o <= ~d;
  endtask
  // Upper word first, lower word commits
  task automatic acc32(input logic w, input logic [`IPS_ADDR_W-1:0] a,
                       input logic [31:0] v, output logic [31:0] q, output logic k,
                       output logic e);
    logic [15:0] h, l;
    logic k1, e1;
    xfer(w, a, v[31:16], h, k1, e1);
    xfer(w, a + 1'b1, v[15:0], l, k, e);
    q = {h, l};
    k = k & k1;
    e = e | e1;
  endtask
endmodule // ips_modbus_master

// ===== testbench/ips_setting_bank_tb_top.sv
// Purpose: Directed register tests of the setting bank
// Assumes: 25 MHz clock, master model does all bus cycles
// Notes:   Expected values follow the coercion rules per field
`timescale 1ns/1ps
`include "ips_setting_regs.vh"
module ips_setting_bank_tb_top;
  logic clk_i, nrst_i, wr, rd, ack, err, lk_a, lk_r, tank, run, tfa, lio;
  logic [`IPS_ADDR_W-1:0] addr;
  logic [15:0] wd, rdat, q16;
  logic [31:0] q;
  logic [3:0] mins;
  logic [13:0] warn, stp;
  logic [1:0] rpol, dm;
  logic [10:0] lo, hi;
  logic k, e;
  int errors, n_tests;
  ips_setting_bank ips_setting_bank_i (.clk_i(clk_i), .nrst_i(nrst_i), .hr_wr_i(wr),
    .hr_rd_i(rd), .hr_addr_i(addr), .hr_wdata_i(wd), .lockout_alarm_i(lk_a),
    .lockout_remote_i(lk_r), .tank_level_module_i(tank), .hr_rdata_o(rdat),
    .hr_ack_o(ack), .hr_err_o(err), .run_cmd_o(run), .dosing_method_o(dm),
    .energy_saving_o(), .measure_metric_o(), .pulses_per_volume_o(), .target_flow_o(),
    .target_flow_active_o(tfa), .input_one_polarity_o(), .input_two_polarity_o(),
    .remote_stop_polarity_o(rpol), .averaging_minutes_o(mins), .reservoir_warn_o(warn),
    .reservoir_stop_o(stp), .dose_check_o(), .loop_input_on_o(lio), .loop_low_current_o(lo),
    .loop_high_current_o(hi));
  ips_modbus_master ips_modbus_master_i (.clk_i(clk_i), .hr_rdata_i(rdat), .hr_ack_i(ack),
    .hr_err_i(err), .hr_wr_o(wr), .hr_rd_o(rd), .hr_addr_o(addr), .hr_wdata_o(wd));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("unexpected %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic rc(input logic [`IPS_ADDR_W-1:0] a, input logic [31:0] x);
    ips_modbus_master_i.acc32(1'b0, a, 32'h0, q, k, e);
    chk($sformatf("read %h", a), x, q);
    chk("read ack", 32'h1, {31'h0, k & !e});
  endtask
  task automatic wc(input logic [`IPS_ADDR_W-1:0] a, input logic [31:0] v,
                    input logic [31:0] x);
    ips_modbus_master_i.acc32(1'b1, a, v, q, k, e);
    chk("write ack", 32'h1, {31'h0, k & !e});
    rc(a, x);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    #(40 * 5000);
    errors++;
    test_done;
  end
  initial begin
    nrst_i = 1'b0;
    {lk_a, lk_r, tank} = 3'b000;
    errors = 0;
    n_tests = 0;
    repeat (4) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    // ==================================================
    // Enumerated fields, every code of dosing, input polarities and window, then illegal ones
    for (int i = 0; i < 3; i++) begin
      wc(`IPS_OFF_DOSING, i, i);
      wc(`IPS_OFF_IN1_POL, i, i);
      wc(`IPS_OFF_IN2_POL, i, i);
      wc(`IPS_OFF_AVG_WINDOW, i, i);
      chk("minutes", (i == 0) ? 32'h1 : (i == 1) ? 32'h5 : 32'hA, {28'h0, mins});
      chk("dosing", i, {30'h0, dm});
    end
    wc(`IPS_OFF_DOSING, 32'h3, 32'h0);
    wc(`IPS_OFF_MEASURE, 32'h1, 32'h1);
    wc(`IPS_OFF_MEASURE, 32'h2, 32'h0);
    wc(`IPS_OFF_IN1_POL, 32'h3, 32'h0);
    wc(`IPS_OFF_IN2_POL, 32'h10002, 32'h0);
    wc(`IPS_OFF_AVG_WINDOW, 32'h3, 32'h0);
    wc(`IPS_OFF_REMOTE_POL, 32'h7, 32'h7);
    chk("remote polarity", 32'h0, {30'h0, rpol});
    wc(`IPS_OFF_CHECK_ON, 32'h1, 32'h1);
    wc(`IPS_OFF_CHECK_ON, 32'h7, 32'h0);
    $display("test enum done");
    // ==================================================
    // Defaults and clamps
    rc(`IPS_OFF_PULSES, 32'h1);
    wc(`IPS_OFF_ENERGY, 32'h4, 32'h4);
    wc(`IPS_OFF_ENERGY, 32'h5, 32'h3);
    wc(`IPS_OFF_ENERGY, 32'h10000, 32'h3);
    wc(`IPS_OFF_PULSES, 32'h0, 32'h1);
    wc(`IPS_OFF_PULSES, 32'h2710, 32'h270F);
    wc(`IPS_OFF_PULSES, 32'h1388, 32'h1388);
    wc(`IPS_OFF_TARGET_FLOW, 32'h00011170, 32'h0000EA60);
    wc(`IPS_OFF_TARGET_FLOW, 32'h5, 32'hA);
    wc(`IPS_OFF_TARGET_FLOW, 32'hEA60, 32'hEA60);
    chk("flow active", 32'h1, {31'h0, tfa});
    wc(`IPS_OFF_LOOP_SELECT, 32'h1, 32'h1);
    chk("loop select", 32'h2, {30'h0, lio, tfa});
    wc(`IPS_OFF_PRESS_ZERO, 32'h12345678, 32'h12345678);
    $display("test clamp done");
    // ==================================================
    // Current loop setpoints clamp against each other
    wc(`IPS_OFF_LOOP_LOW, 32'h64, 32'h190);
    wc(`IPS_OFF_LOOP_LOW, 32'h834, 32'h7CF);
    wc(`IPS_OFF_LOOP_LOW, 32'h3E8, 32'h3E8);
    wc(`IPS_OFF_LOOP_HIGH, 32'h1F4, 32'h3EA);
    wc(`IPS_OFF_LOOP_HIGH, 32'hBB8, 32'h7D0);
    chk("loop pair", {10'h0, 11'h3E8, 11'h7D0}, {10'h0, lo, hi});
    $display("test loop done");
    // ==================================================
    // Run state, lockouts and tank module
    wc(`IPS_OFF_RUN_STATE, 32'h1, 32'h1);
    chk("run cmd", 32'h1, {31'h0, run});
    @(posedge clk_i);
    {lk_a, lk_r} <= 2'b11;
    rc(`IPS_OFF_RUN_STATE, 32'h2);
    chk("run cmd", 32'h0, {31'h0, run});
    @(posedge clk_i);
    lk_a <= 1'b0;
    rc(`IPS_OFF_RUN_STATE, 32'h3);
    @(posedge clk_i);
    lk_r <= 1'b0;
    rc(`IPS_OFF_RUN_STATE, 32'h1);
    wc(`IPS_OFF_RUN_STATE, 32'h2, 32'h0);
    wc(`IPS_OFF_RES_WARN, 32'h1F4, 32'h1F4);
    chk("warn level", 32'h0, {18'h0, warn});
    @(posedge clk_i);
    tank <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("warn level", 32'h1F4, {18'h0, warn});
    wc(`IPS_OFF_RES_STOP, 32'h2710, 32'h2710);
    chk("stop level", 32'h0, {18'h0, stp});
    $display("test run done");
    // ==================================================
    // Refusals: lone lower word, unmapped address
    ips_modbus_master_i.xfer(1'b1, `IPS_OFF_PULSES + 1'b1, 16'h0005, q16, k, e);
    chk("lone lower err", 32'h1, {31'h0, k & e});
    rc(`IPS_OFF_PULSES, 32'h1388);
    ips_modbus_master_i.acc32(1'b0, `IPS_LAST_ADDR + 1'b1, 32'h0, q, k, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    $display("test refuse done");
    test_done;
  end
endmodule // ips_setting_bank_tb_top
